// ==== serial_command_input_port.sv ====
// serial command input port: 24-bit shift, strobe capture, decode, readback
//
// Contract
// RULE1: serial clock runs at most 30 MHz; host must not exceed it.
// RULE2: 24-bit input shift register, received most significant bit first.
// RULE3: data input sampled and shifted on every serial clock rising edge.
// RULE4: bits 23..16 are address byte, bits 15..0 are data word.
// RULE5: every strobe rising edge captures the 24-bit shift register unconditionally.
// RULE6: shifting continues regardless of strobe; capture holds latest 24 bits.
// RULE7: host raises strobe only after correct bit count, or exact burst.
// RULE8: write cycle starts at first rising edge after the previous strobe.
// RULE9: host applies exactly 24 rising edges per word before the strobe.
// RULE10: strobe after fewer than 24 edges is an invalid write.
// RULE11: strobe after more than 24 edges is invalid input too.
// RULE12: address 00 no-op, 01 output code write, 55 output setup write.
// RULE13: address 02 requests readback by read address; 56 soft reset.
// RULE14: read address 00 status, 01 output code, 10 output setup.
// RULE15: after readback, next no-op word shifts selected register out.
// RULE16: serial output off by default; strobe enables after readback, next disables.
// RULE17: soft reset clears every register like power-on, output disabled; the code leaves the shift and capture registers holding the reset word.
// RULE18: unknown address byte is ignored, registers unchanged.
`timescale 1ns/1ps
`default_nettype none
module serial_command_input_port (
	// system
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// serial link pins
	input wire logic i_sclk,
	input wire logic i_serial_in,
	input wire logic i_load_strobe,
	output logic o_serial_out,
	output logic o_serial_out_oe,
	// register contents and status
	input wire logic [15:0] i_status,
	output logic [15:0] o_output_code,
	output logic [15:0] o_output_setup,
	output logic o_word_invalid
);
	logic sclk_m_q, sclk_s_q, sclk_p_q;
	logic sdi_m_q, sdi_s_q;
	logic stb_m_q, stb_s_q, stb_p_q;
	logic [23:0] shift_q;
	logic [23:0] cap_q;
	logic [4:0] edge_cnt_q;
	logic [15:0] code_q;
	logic [15:0] setup_q;
	logic [23:0] out_sr_q;
	logic oe_q;
	logic invalid_q;

	wire sclk_rise = sclk_s_q & ~sclk_p_q;
	wire sclk_fall = ~sclk_s_q & sclk_p_q;
	wire stb_rise = stb_s_q & ~stb_p_q;
	// RULE4 field split
	wire [7:0] addr_byte = shift_q[serial_command_pkg::ADDR_MSB:serial_command_pkg::ADDR_LSB];
	wire [15:0] data_word = shift_q[serial_command_pkg::DATA_MSB:serial_command_pkg::DATA_LSB];
	wire [1:0] rd_sel = data_word[serial_command_pkg::RD_SEL_MSB:0];
	// RULE10 RULE11 exact count
	wire word_ok = edge_cnt_q == serial_command_pkg::EDGE_CNT_WORD;
	wire take = stb_rise & word_ok;
	// RULE12 address decode
	wire wr_code = take & (addr_byte == serial_command_pkg::ADDR_OUTPUT_CODE);
	wire wr_setup = take & (addr_byte == serial_command_pkg::ADDR_OUTPUT_SETUP);
	// RULE13 readback and reset codes
	wire rd_req = take & (addr_byte == serial_command_pkg::ADDR_READBACK);
	wire soft_rst = take & (addr_byte == serial_command_pkg::ADDR_SOFT_RESET);
	// RULE14 readback source select; unused code reads zero
	wire [15:0] rd_data = (rd_sel == serial_command_pkg::RD_STATUS) ? i_status :
		(rd_sel == serial_command_pkg::RD_OUTPUT_CODE) ? code_q :
		(rd_sel == serial_command_pkg::RD_OUTPUT_SETUP) ? setup_q :
		serial_command_pkg::REG_RESET;

	// RULE1 two-stage sync; 8 ns sampling resolves links up to 30 MHz
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sclk_m_q <= 1'b0;
			sclk_s_q <= 1'b0;
			sclk_p_q <= 1'b0;
			sdi_m_q <= 1'b0;
			sdi_s_q <= 1'b0;
			stb_m_q <= 1'b0;
			stb_s_q <= 1'b0;
			stb_p_q <= 1'b0;
		end
		else
		begin
			sclk_m_q <= i_sclk;
			sclk_s_q <= sclk_m_q;
			sclk_p_q <= sclk_s_q;
			sdi_m_q <= i_serial_in;
			sdi_s_q <= sdi_m_q;
			stb_m_q <= i_load_strobe;
			stb_s_q <= stb_m_q;
			stb_p_q <= stb_s_q;
		end
	end

	// RULE2 RULE3 RULE6 shift msb first whatever the strobe does
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			shift_q <= serial_command_pkg::SHIFT_RESET;
		else if (sclk_rise)
			shift_q <= {shift_q[22:0], sdi_s_q};
	end

	// RULE8 count restarts at each strobe; an edge in the strobe cycle counts as first
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			edge_cnt_q <= serial_command_pkg::EDGE_CNT_RESET;
		else if (stb_rise)
			edge_cnt_q <= {4'h0, sclk_rise};
		else if (sclk_rise && edge_cnt_q != serial_command_pkg::EDGE_CNT_SAT)
			edge_cnt_q <= edge_cnt_q + 5'h01;
	end

	// RULE5 unconditional capture
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cap_q <= serial_command_pkg::SHIFT_RESET;
		else if (stb_rise)
			cap_q <= shift_q;
	end

	// RULE12 RULE17 RULE18 register writes; unknown codes fall through untouched
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			code_q <= serial_command_pkg::REG_RESET;
			setup_q <= serial_command_pkg::REG_RESET;
			invalid_q <= 1'b0;
		end
		else
		begin
			invalid_q <= stb_rise & ~word_ok;
			if (soft_rst)
			begin
				code_q <= serial_command_pkg::REG_RESET;
				setup_q <= serial_command_pkg::REG_RESET;
			end
			if (wr_code)
				code_q <= data_word;
			if (wr_setup)
				setup_q <= data_word;
		end
	end

	// RULE15 RULE16 readout enable and shift on falling link edges
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			oe_q <= 1'b0;
			out_sr_q <= serial_command_pkg::SHIFT_RESET;
		end
		else if (soft_rst)
		begin
			oe_q <= 1'b0;
			out_sr_q <= serial_command_pkg::SHIFT_RESET;
		end
		else if (rd_req)
		begin
			oe_q <= 1'b1;
			out_sr_q <= {serial_command_pkg::READOUT_PAD, rd_data};
		end
		else if (stb_rise)
			oe_q <= 1'b0;
		else if (sclk_fall && oe_q)
			out_sr_q <= {out_sr_q[22:0], 1'b0};
	end

	assign o_serial_out = out_sr_q[23];
	assign o_serial_out_oe = oe_q;
	assign o_output_code = code_q;
	assign o_output_setup = setup_q;
	assign o_word_invalid = invalid_q;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	a_shift_msb_first: assert property (sclk_rise |=> shift_q == {$past(shift_q[22:0]), $past(sdi_s_q)}) // RULE3
		else $error("shift register did not take the sampled bit");
	a_capture_latest_word: assert property (stb_rise |=> cap_q == $past(shift_q)) // RULE5
		else $error("strobe did not capture the shift register");
	a_count_restart: assert property (stb_rise && !sclk_rise |=> edge_cnt_q == 5'h00) // RULE8
		else $error("edge count not restarted by strobe");
	a_bad_count_ignored: assert property (stb_rise && !word_ok |=> $stable(code_q) && $stable(setup_q) && o_word_invalid) // RULE10
		else $error("miscounted word changed a register");
	a_code_write: assert property (wr_code |=> code_q == $past(data_word)) // RULE12
		else $error("output code write lost");
	a_setup_write: assert property (wr_setup |=> setup_q == $past(data_word)) // RULE12
		else $error("output setup write lost");
	a_readback_load: assert property (rd_req |=> oe_q && out_sr_q == {8'h00, $past(rd_data)}) // RULE14
		else $error("readback did not load selected register");
	a_readout_release: assert property (stb_rise && oe_q && !rd_req |=> !oe_q) // RULE16
		else $error("serial output not released by strobe");
	a_readout_shift: assert property (sclk_fall && oe_q && !stb_rise |=> out_sr_q == {$past(out_sr_q[22:0]), 1'b0}) // RULE15
		else $error("readout did not advance on falling edge");
	a_soft_reset_clear: assert property (soft_rst |=> code_q == 16'h0000 && setup_q == 16'h0000 && !oe_q) // RULE17
		else $error("soft reset left state behind");
	a_unknown_ignored: assert property (take && addr_byte != 8'h01 && addr_byte != 8'h55 && addr_byte != 8'h56 |=> $stable(code_q) && $stable(setup_q)) // RULE18
		else $error("unknown address changed a register");
	a_shift_hold: assert property (!sclk_rise |=> $stable(shift_q)) // RULE3
		else $error("shift register moved without a link clock rise");
	a_valid_no_flag: assert property (stb_rise && word_ok |=> !o_word_invalid) // RULE10
		else $error("correctly counted word flagged invalid");
	a_oe_needs_readback: assert property (stb_rise && !rd_req |=> !oe_q) // RULE16
		else $error("serial output enabled without a readback request");

	c_code_write: cover property (wr_code);
	c_readback_then_release: cover property (rd_req ##[1:1000] stb_rise ##1 !oe_q);
	c_soft_reset: cover property (soft_rst);
	c_short_word: cover property (stb_rise && edge_cnt_q < 5'h18);
	c_long_word: cover property (stb_rise && edge_cnt_q == serial_command_pkg::EDGE_CNT_SAT);
endmodule
`default_nettype wire

// ==== serial_command_pkg.sv ====
// constants for the serial command input port
package serial_command_pkg;
	localparam int WORD_BITS = 24;
	localparam logic [4:0] EDGE_CNT_WORD = 5'h18;
	localparam logic [4:0] EDGE_CNT_SAT = 5'h19;
	localparam logic [4:0] EDGE_CNT_RESET = 5'h00;
	localparam int ADDR_MSB = 23;
	localparam int ADDR_LSB = 16;
	localparam int DATA_MSB = 15;
	localparam int DATA_LSB = 0;
	localparam int RD_SEL_MSB = 1;
	localparam logic [7:0] ADDR_NOP = 8'h00;
	localparam logic [7:0] ADDR_OUTPUT_CODE = 8'h01;
	localparam logic [7:0] ADDR_READBACK = 8'h02;
	localparam logic [7:0] ADDR_OUTPUT_SETUP = 8'h55;
	localparam logic [7:0] ADDR_SOFT_RESET = 8'h56;
	localparam logic [1:0] RD_STATUS = 2'h0;
	localparam logic [1:0] RD_OUTPUT_CODE = 2'h1;
	localparam logic [1:0] RD_OUTPUT_SETUP = 2'h2;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [23:0] SHIFT_RESET = 24'h000000;
	localparam logic [7:0] READOUT_PAD = 8'h00;
	// link rate limit and its cost in system cycles
	localparam int SYS_CLK_HZ = 125000000;
	localparam int SCLK_MAX_HZ = 30000000;
	localparam int SCLK_MIN_PERIOD_CYC = (SYS_CLK_HZ + SCLK_MAX_HZ - 1) / SCLK_MAX_HZ;
endpackage

// ==== host_link_model.sv ====
// host serial master model for the command port link
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	// system
	input wire logic i_clk_sys,
	// link
	output logic o_sclk,
	output logic o_serial_in,
	output logic o_load_strobe,
	input wire logic i_serial_out,
	input wire logic i_serial_out_oe
);
	initial
	begin
		o_sclk = 1'b0;
		o_serial_in = 1'b0;
		o_load_strobe = 1'b0;
	end
	// counted edges, slow rate
	// clock stands low outside frames, 20 sys cycles a bit
	task automatic send(input logic [23:0] w, input int n, output logic [23:0] rd);
		rd = 24'h000000;
		// 10 low plus 10 high sys cycles: a 160 ns link period
		for (int i = n - 1; i >= 0; i--)
		begin
			o_serial_in = (i < 24) ? w[i] : 1'b0;
			repeat (10) @(negedge i_clk_sys);
			// readout taken at each rise
			// released line shows the inverse of the last bit
			rd = {rd[22:0], i_serial_out_oe ? i_serial_out : ~rd[0]};
			o_sclk = 1'b1;
			repeat (10) @(negedge i_clk_sys);
			o_sclk = 1'b0;
		end
		// strobe only after the last edge
		repeat (5) @(negedge i_clk_sys);
		o_load_strobe = 1'b1;
		repeat (8) @(negedge i_clk_sys);
		o_load_strobe = 1'b0;
		repeat (5) @(negedge i_clk_sys);
	endtask
endmodule
`default_nettype wire

// ==== serial_command_input_port_test.sv ====
// self-checking bench for the serial command input port
`timescale 1ns/1ps
`default_nettype none
module serial_command_input_port_test;
	localparam logic [15:0] CODE = 16'hBEEF;
	localparam logic [15:0] SETUP = 16'h1234;
	localparam logic [15:0] STATUS = 16'hA5C3;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sclk, serial_in, stb, serial_out, serial_out_oe, invalid;
	int invalid_pulses = 0;
	logic [15:0] code, setup;
	logic [23:0] rd;
	int fails = 0;
	int compares = 0;
	always #4 clk = ~clk;
	always @(posedge clk) if (invalid === 1'b1) invalid_pulses <= invalid_pulses + 1;
	serial_command_input_port uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_sclk(sclk),
		.i_serial_in(serial_in), .i_load_strobe(stb), .o_serial_out(serial_out),
		.o_serial_out_oe(serial_out_oe), .i_status(STATUS), .o_output_code(code),
		.o_output_setup(setup), .o_word_invalid(invalid));
	host_link_model host (.i_clk_sys(clk), .o_sclk(sclk), .o_serial_in(serial_in),
		.o_load_strobe(stb), .i_serial_out(serial_out), .i_serial_out_oe(serial_out_oe));
	task automatic chk_val(input string nm, input logic [23:0] e, input logic [23:0] g);
		compares++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_val(nm, {23'h000000, e}, {23'h000000, g});
	endtask
	task automatic print_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic test_reset_state;
		chk_val("code", 24'h000000, {8'h00, code});
		chk_val("setup", 24'h000000, {8'h00, setup});
		chk_bit("oe", 1'b0, serial_out_oe);
	endtask
	task automatic test_writes;
		host.send({8'h01, CODE}, 24, rd);
		chk_val("code", {8'h00, CODE}, {8'h00, code});
		host.send({8'h55, SETUP}, 24, rd);
		chk_val("setup", {8'h00, SETUP}, {8'h00, setup});
		chk_val("invalid pulses", 24'h000000, 24'(invalid_pulses));
	endtask
	task automatic test_ignored;
		host.send(24'h00FFFF, 24, rd);
		host.send(24'h7F0F0F, 24, rd);
		chk_val("code", {8'h00, CODE}, {8'h00, code});
		chk_val("setup", {8'h00, SETUP}, {8'h00, setup});
	endtask
	task automatic test_bad_count;
		int p;
		for (int n = 23; n <= 25; n += 2)
		begin
			p = invalid_pulses;
			host.send(24'h010000, n, rd);
			chk_val("invalid pulses", 24'(p + 1), 24'(invalid_pulses));
			chk_val("code", {8'h00, CODE}, {8'h00, code});
		end
	endtask
	task automatic test_readback;
		logic [15:0] e;
		// read address 11 is unused and reads zero
		for (int s = 0; s < 4; s++)
		begin
			e = (s == 0) ? STATUS : (s == 1) ? CODE : (s == 2) ? SETUP : 16'h0000;
			host.send({8'h02, 14'h0000, s[1:0]}, 24, rd);
			chk_bit("oe", 1'b1, serial_out_oe);
			host.send(24'h000000, 24, rd);
			chk_val("readout", {8'h00, e}, rd);
			chk_bit("oe", 1'b0, serial_out_oe);
		end
	endtask
	task automatic test_soft_reset;
		host.send(24'h56FFFF, 24, rd);
		test_reset_state();
	endtask
	initial
	begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		test_reset_state();
		test_writes();
		test_ignored();
		test_bad_count();
		test_readback();
		test_soft_reset();
		print_verdict();
	end
	// about 15 words of 500 cycles each, so a wide margin
	initial
	begin
		#200000;
		fails++;
		print_verdict();
	end
endmodule
`default_nettype wire
